//--- design/rpsc_pkg.sv
// package: register map, field layout, reset values and codes of the radio status/config bank
package rpsc_pkg;
	localparam logic [11:0] OFF_INT_ENABLE  = 12'h304;
	localparam logic [11:0] OFF_INT_DISABLE = 12'h308;
	localparam logic [11:0] OFF_CRC_RESULT  = 12'h400;
	localparam logic [11:0] OFF_RX_LADDR    = 12'h408;
	localparam logic [11:0] OFF_RX_CHECK    = 12'h40c;
	localparam logic [11:0] OFF_DEV_MATCH   = 12'h410;
	localparam logic [11:0] OFF_PAY_STATUS  = 12'h414;
	localparam logic [11:0] OFF_TONE_INFO   = 12'h44c;
	localparam logic [11:0] OFF_DF_STATE    = 12'h458;
	localparam logic [11:0] OFF_PKT_PTR     = 12'h504;
	localparam logic [11:0] OFF_FREQ        = 12'h508;
	localparam logic [11:0] OFF_TX_POWER    = 12'h50c;
	localparam logic [11:0] OFF_MODE        = 12'h510;
	localparam logic [11:0] OFF_PCFG0       = 12'h514;
	localparam logic [11:0] OFF_PCFG1       = 12'h518;
	localparam logic [11:0] OFF_EVT_STATUS  = 12'h600;

	// event bit positions in status and enable registers
	localparam int EVB_RATE_SWITCH = 18;
	localparam int EVB_TX_READY    = 19;
	localparam int EVB_RX_READY    = 20;
	localparam int EVB_MHR_MATCH   = 21;
	localparam int EVB_PHY_END     = 23;
	localparam int EVB_TONE_FOUND  = 24;

	localparam int FREQ_MAP_BIT  = 8;
	localparam int RATE_INDICATOR_STATUS_BIT    = 1;
	localparam int SAMPLER_BIT   = 4;

	localparam logic [31:0] FREQ_RESET   = 32'h0000_0002;
	localparam logic [31:0] FREQ_MASK    = 32'h0000_017f;
	localparam logic [31:0] POWER_MASK   = 32'h0000_00ff;
	localparam logic [31:0] MODE_MASK    = 32'h0000_000f;
	localparam logic [31:0] EVT_MASK     = 32'h01bc_0000;

	localparam logic [11:0] BASE_DEFAULT_MHZ = 12'h960;
	localparam logic [11:0] BASE_LOW_MHZ     = 12'h938;
	localparam logic [6:0]  CHAN_MAX         = 7'h64;

	localparam logic [3:0] MODE_PROP_1M  = 4'h0;
	localparam logic [3:0] MODE_PROP_2M  = 4'h1;
	localparam logic [3:0] MODE_LE_1M    = 4'h3;
	localparam logic [3:0] MODE_LE_2M    = 4'h4;
	localparam logic [3:0] MODE_LR_125K  = 4'h5;
	localparam logic [3:0] MODE_LR_500K  = 4'h6;
	localparam logic [3:0] MODE_PAN_250K = 4'hf;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- design/rpsc_top.sv
// module: AXI4-Lite register bank with receive status capture and radio configuration outputs
// What this block does
// - write one to disable bit disables interrupt
// - rate-switch event on 125k to 500k indicator
// - crc result reads 1 ok, 0 error
// - three-bit logical address of last packet
// - 24-bit received crc value readable
// - three-bit device address match index
// - payload status: 1 when longer than maximum
// - rate status: 0 125k, 1 500k
// - antenna switch state read-only, codes 0-5
// - sampler state bit: idle or sampling
// - carrier equals base plus channel 0..100 (channel field is not limited; 0..127 accepted)
// - map bit selects 2360 MHz base
// - output power signed dBm byte
// - mode field selects rate and modulation
// - long range: tx selected, rx both rates
// - payload truncated to maximum length
//
// The AXI4-Lite register port was chosen for this implementation.
module rpsc_top
	import rpsc_pkg::*;
(
	input  wire logic        CLK_SYS,
	input  wire logic        RST_B,
	input  wire logic [11:0] S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [11:0] S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	input  wire logic        RX_FRAME_START,
	input  wire logic        RX_END,
	input  wire logic        RX_CRC_OK,
	input  wire logic [2:0]  RX_LOGICAL_ADDR,
	input  wire logic [23:0] RX_CHECK_VALUE,
	input  wire logic [2:0]  RX_MATCH_INDEX,
	input  wire logic [7:0]  RX_PAYLOAD_LEN,
	input  wire logic [7:0]  RX_TONE_INFO,
	input  wire logic        CODING_INDICATOR_VALID,
	input  wire logic        CODING_INDICATOR,
	input  wire logic [2:0]  ANTENNA_SWITCH_FSM_STATE,
	input  wire logic        SAMPLER_FSM_STATE,
	input  wire logic        TRANSMIT_READY_EVENT,
	input  wire logic        RECEIVE_READY_EVENT,
	input  wire logic        MAC_HEADER_MATCH_EVENT,
	input  wire logic        PHYSICAL_END_EVENT,
	input  wire logic        TONE_EXTENSION_FOUND_EVENT,
	output logic [31:0]      PACKET_DMA_POINTER,
	output logic [11:0]      CARRIER_MHZ,
	output logic [7:0]       OUTPUT_POWER,
	output logic [3:0]       RADIO_MODE,
	output logic             TX_RATE_500K,
	output logic             RX_ACCEPT_BOTH_RATES,
	output logic [7:0]       MAX_PAYLOAD_LENGTH,
	output logic [7:0]       RX_STORED_LEN,
	output logic             RX_TRUNCATED,
	output logic             IRQ
);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] strb_mask(input logic [3:0] strb);
		return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		return (old & ~strb_mask(strb)) | (data & strb_mask(strb));
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic        aw_pend;
	logic [11:0] aw_addr;
	logic        w_pend;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        bvalid;
	logic [1:0]  bresp;
	logic        rvalid;
	logic [31:0] rdata;
	logic [1:0]  rresp;

	logic [31:0] int_enable;
	logic [31:0] evt_status;
	logic [31:0] pkt_ptr;
	logic [31:0] freq_reg;
	logic [31:0] power_reg;
	logic [31:0] mode_reg;
	logic [31:0] pcfg0;
	logic [31:0] pcfg1;

	logic        crc_ok;
	logic [2:0]  rx_laddr;
	logic [23:0] rx_check;
	logic [2:0]  match_idx;
	logic        pay_long;
	logic        rate_stat;
	logic [7:0]  tone_info;
	logic        rx_rate;
	logic        rate_evt;

	wire         do_write = aw_pend & w_pend & ~bvalid;
	wire  [31:0] wmask    = w_data & strb_mask(w_strb);
	wire         wr_en    = do_write & (aw_addr == OFF_INT_ENABLE);
	wire         wr_dis   = do_write & (aw_addr == OFF_INT_DISABLE);
	wire         wr_evt   = do_write & (aw_addr == OFF_EVT_STATUS);
	wire         wr_ptr   = do_write & (aw_addr == OFF_PKT_PTR);
	wire         wr_freq  = do_write & (aw_addr == OFF_FREQ);
	wire         wr_pow   = do_write & (aw_addr == OFF_TX_POWER);
	wire         wr_mode  = do_write & (aw_addr == OFF_MODE);
	wire         wr_pc0   = do_write & (aw_addr == OFF_PCFG0);
	wire         wr_pc1   = do_write & (aw_addr == OFF_PCFG1);

	// read-only status offsets accept writes silently; only holes answer with an error
	function automatic logic mapped(input logic [11:0] a);
		return a == OFF_INT_ENABLE || a == OFF_INT_DISABLE || a == OFF_CRC_RESULT
			|| a == OFF_RX_LADDR || a == OFF_RX_CHECK || a == OFF_DEV_MATCH
			|| a == OFF_PAY_STATUS || a == OFF_TONE_INFO || a == OFF_DF_STATE
			|| a == OFF_PKT_PTR || a == OFF_FREQ || a == OFF_TX_POWER || a == OFF_MODE
			|| a == OFF_PCFG0 || a == OFF_PCFG1 || a == OFF_EVT_STATUS;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	assign S_AXI_AWREADY = ~aw_pend;
	assign S_AXI_WREADY  = ~w_pend;
	assign S_AXI_BVALID  = bvalid;
	assign S_AXI_BRESP   = bresp;
	assign S_AXI_ARREADY = ~rvalid;
	assign S_AXI_RVALID  = rvalid;
	assign S_AXI_RDATA   = rdata;
	assign S_AXI_RRESP   = rresp;

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			aw_pend <= 1'b0;
			aw_addr <= 12'h000;
			w_pend  <= 1'b0;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end
		else
		begin
			if (S_AXI_AWVALID && !aw_pend)
			begin
				aw_pend <= 1'b1;
				aw_addr <= {S_AXI_AWADDR[11:2], 2'b00};
			end
			if (S_AXI_WVALID && !w_pend)
			begin
				w_pend <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
			if (do_write)
			begin
				aw_pend <= 1'b0;
				w_pend  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid && S_AXI_BREADY)
				bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	wire  [11:0] ra = {S_AXI_ARADDR[11:2], 2'b00};
	logic [31:0] next_rdata;

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		unique case (ra)
			OFF_INT_ENABLE,
			OFF_INT_DISABLE: next_rdata = int_enable;
			OFF_CRC_RESULT:  next_rdata = {31'h0, crc_ok};
			OFF_RX_LADDR:    next_rdata = {29'h0, rx_laddr};
			OFF_RX_CHECK:    next_rdata = {8'h00, rx_check};
			OFF_DEV_MATCH:   next_rdata = {29'h0, match_idx};
			OFF_PAY_STATUS:  next_rdata = {30'h0, rate_stat, pay_long};
			OFF_TONE_INFO:   next_rdata = {24'h0, tone_info};
			OFF_DF_STATE:    next_rdata = {27'h0, SAMPLER_FSM_STATE, 1'b0,
				ANTENNA_SWITCH_FSM_STATE};
			OFF_PKT_PTR:     next_rdata = pkt_ptr;
			OFF_FREQ:        next_rdata = freq_reg;
			OFF_TX_POWER:    next_rdata = power_reg;
			OFF_MODE:        next_rdata = mode_reg;
			OFF_PCFG0:       next_rdata = pcfg0;
			OFF_PCFG1:       next_rdata = pcfg1;
			OFF_EVT_STATUS:  next_rdata = evt_status;
			default:         next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= RESP_OKAY;
		end
		else if (S_AXI_ARVALID && !rvalid)
		begin
			rvalid <= 1'b1;
			rdata  <= next_rdata;
			rresp  <= mapped(ra) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid && S_AXI_RREADY)
			rvalid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers; reserved bits are masked so they read zero
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			int_enable <= 32'h0000_0000;
			pkt_ptr    <= 32'h0000_0000;
			freq_reg   <= FREQ_RESET;
			power_reg  <= 32'h0000_0000;
			mode_reg   <= 32'h0000_0000;
			pcfg0      <= 32'h0000_0000;
			pcfg1      <= 32'h0000_0000;
		end
		else
		begin
			if (wr_en)
				int_enable <= int_enable | (wmask & EVT_MASK);
			if (wr_dis)
				int_enable <= int_enable & ~wmask;
			if (wr_ptr)
				pkt_ptr <= merge(pkt_ptr, w_data, w_strb);
			if (wr_freq)
				freq_reg <= merge(freq_reg, w_data, w_strb) & FREQ_MASK;
			if (wr_pow)
				power_reg <= merge(power_reg, w_data, w_strb) & POWER_MASK;
			if (wr_mode)
				mode_reg <= merge(mode_reg, w_data, w_strb) & MODE_MASK;
			if (wr_pc0)
				pcfg0 <= merge(pcfg0, w_data, w_strb);
			if (wr_pc1)
				pcfg1 <= merge(pcfg1, w_data, w_strb);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	wire        lr_mode  = (mode_reg[3:0] == MODE_LR_125K) || (mode_reg[3:0] == MODE_LR_500K);
	wire [7:0]  max_len  = pcfg1[7:0];
	wire        too_long = RX_PAYLOAD_LEN > max_len;
	wire        ci_boost = lr_mode & CODING_INDICATOR_VALID & CODING_INDICATOR & ~rx_rate;
	wire [11:0] base_mhz = freq_reg[FREQ_MAP_BIT] ? BASE_LOW_MHZ : BASE_DEFAULT_MHZ;

	assign PACKET_DMA_POINTER   = pkt_ptr;
	assign CARRIER_MHZ          = base_mhz + {5'h00, freq_reg[6:0]};
	assign OUTPUT_POWER         = power_reg[7:0];
	assign RADIO_MODE           = mode_reg[3:0];
	assign TX_RATE_500K         = mode_reg[3:0] == MODE_LR_500K;
	assign RX_ACCEPT_BOTH_RATES = lr_mode;
	assign MAX_PAYLOAD_LENGTH   = max_len;
	assign RX_STORED_LEN        = too_long ? max_len : RX_PAYLOAD_LEN;
	assign RX_TRUNCATED         = too_long;

	// every frame starts at the slow rate; the indicator can only raise it
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			rx_rate  <= 1'b0;
			rate_evt <= 1'b0;
		end
		else
		begin
			rate_evt <= ci_boost;
			if (RX_FRAME_START)
				rx_rate <= 1'b0;
			else if (ci_boost)
				rx_rate <= 1'b1;
		end
	end

	// status holds until the next packet end so software can read it at leisure
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			crc_ok    <= 1'b0;
			rx_laddr  <= 3'h0;
			rx_check  <= 24'h00_0000;
			match_idx <= 3'h0;
			pay_long  <= 1'b0;
			rate_stat <= 1'b0;
			tone_info <= 8'h00;
		end
		else if (RX_END)
		begin
			crc_ok    <= RX_CRC_OK;
			rx_laddr  <= RX_LOGICAL_ADDR;
			rx_check  <= RX_CHECK_VALUE;
			match_idx <= RX_MATCH_INDEX;
			pay_long  <= too_long;
			rate_stat <= rx_rate;
			tone_info <= RX_TONE_INFO;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic [31:0] evt_in;

	always_comb
	begin
		evt_in                  = 32'h0000_0000;
		evt_in[EVB_RATE_SWITCH] = rate_evt;
		evt_in[EVB_TX_READY]    = TRANSMIT_READY_EVENT;
		evt_in[EVB_RX_READY]    = RECEIVE_READY_EVENT;
		evt_in[EVB_MHR_MATCH]   = MAC_HEADER_MATCH_EVENT;
		evt_in[EVB_PHY_END]     = PHYSICAL_END_EVENT;
		evt_in[EVB_TONE_FOUND]  = TONE_EXTENSION_FOUND_EVENT;
	end

	// a new event in the clearing cycle survives: set is applied after clear
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			evt_status <= 32'h0000_0000;
		else
			evt_status <= (evt_status & ~(wr_evt ? wmask : 32'h0)) | evt_in;
	end

	assign IRQ = |(evt_status & int_enable);

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_B);

	int_disable_a: assert property (
		wr_dis && !wr_en |=> (int_enable & $past(wmask)) == 32'h0)
		else $error("disable write left an interrupt enabled");
	rate_event_a: assert property (
		ci_boost && !RX_FRAME_START |=> rate_evt && rx_rate ##1 evt_status[EVB_RATE_SWITCH])
		else $error("rate switch not raised");
	crc_capture_a: assert property (
		RX_END |=> crc_ok == $past(RX_CRC_OK) && rx_check == $past(RX_CHECK_VALUE))
		else $error("crc result not captured");
	addr_capture_a: assert property (
		RX_END |=> rx_laddr == $past(RX_LOGICAL_ADDR) && match_idx == $past(RX_MATCH_INDEX))
		else $error("address fields not captured");
	status_hold_a: assert property (
		!RX_END |=> $stable(crc_ok) && $stable(pay_long) && $stable(rx_laddr))
		else $error("receive status changed without packet end");
	len_status_a: assert property (
		RX_END |=> pay_long == ($past(RX_PAYLOAD_LEN) > $past(max_len)))
		else $error("payload status wrong");
	truncate_a: assert property (
		RX_TRUNCATED ? RX_STORED_LEN == max_len && RX_PAYLOAD_LEN > max_len
			: RX_STORED_LEN == RX_PAYLOAD_LEN && RX_PAYLOAD_LEN <= max_len)
		else $error("payload not truncated");
	event_sticky_a: assert property (
		(evt_in != 32'h0) |=> (evt_status & $past(evt_in)) == $past(evt_in))
		else $error("event lost in clearing cycle");
	carrier_map_a: assert property (
		wr_freq |=> CARRIER_MHZ == ($past(w_data[FREQ_MAP_BIT] & w_strb[1]) ? 12'h938 : 12'h960)
			+ {5'h00, freq_reg[6:0]})
		else $error("carrier base wrong after map write");
	tx_rate_a: assert property (
		TX_RATE_500K |-> RX_ACCEPT_BOTH_RATES && RADIO_MODE == 4'h6)
		else $error("long range transmit rate inconsistent");
	rate_status_a: assert property (
		RX_END && !RX_FRAME_START |=> rate_stat == $past(rx_rate))
		else $error("rate status not captured");

endmodule

//--- verification/radio_packet_status_config_bench.sv
// bench: register-level tests of the radio status and configuration bank
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module radio_packet_status_config_bench
	import rpsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK_SYS, RST_B, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID;
	logic        S_AXI_RREADY, RX_FRAME_START, RX_END, RX_CRC_OK, CODING_INDICATOR_VALID;
	logic        CODING_INDICATOR, SAMPLER_FSM_STATE, TRANSMIT_READY_EVENT, RECEIVE_READY_EVENT;
	logic        MAC_HEADER_MATCH_EVENT, PHYSICAL_END_EVENT, TONE_EXTENSION_FOUND_EVENT;
	logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR, CARRIER_MHZ;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA, PACKET_DMA_POINTER;
	logic [3:0]  S_AXI_WSTRB, RADIO_MODE;
	logic [2:0]  RX_LOGICAL_ADDR, RX_MATCH_INDEX, ANTENNA_SWITCH_FSM_STATE;
	logic [23:0] RX_CHECK_VALUE;
	logic [7:0]  RX_PAYLOAD_LEN, RX_TONE_INFO, OUTPUT_POWER, MAX_PAYLOAD_LENGTH, RX_STORED_LEN;
	logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic        TX_RATE_500K, RX_ACCEPT_BOTH_RATES, RX_TRUNCATED, IRQ;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
	int          miscompares, compares, cyc;
	logic [7:0]  pw [10] = '{8'h04, 8'h03, 8'h00, 8'hfc, 8'hf8, 8'hf4, 8'hf0, 8'hec, 8'hd8, 8'he2};
	logic [3:0]  md [7]  = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'hf};
	logic [11:0] ro [11] = '{OFF_CRC_RESULT, OFF_RX_LADDR, OFF_RX_CHECK, OFF_DEV_MATCH,
		OFF_PAY_STATUS, OFF_TONE_INFO, OFF_PKT_PTR, OFF_TX_POWER, OFF_MODE, OFF_PCFG0, OFF_PCFG1};

	rpsc_top i_dut (.CLK_SYS, .RST_B, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
		.S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
		.S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
		.S_AXI_RVALID, .S_AXI_RREADY, .RX_FRAME_START, .RX_END, .RX_CRC_OK, .RX_LOGICAL_ADDR,
		.RX_CHECK_VALUE, .RX_MATCH_INDEX, .RX_PAYLOAD_LEN, .RX_TONE_INFO, .CODING_INDICATOR_VALID,
		.CODING_INDICATOR, .ANTENNA_SWITCH_FSM_STATE, .SAMPLER_FSM_STATE, .TRANSMIT_READY_EVENT,
		.RECEIVE_READY_EVENT, .MAC_HEADER_MATCH_EVENT, .PHYSICAL_END_EVENT,
		.TONE_EXTENSION_FOUND_EVENT, .PACKET_DMA_POINTER, .CARRIER_MHZ, .OUTPUT_POWER,
		.RADIO_MODE, .TX_RATE_500K, .RX_ACCEPT_BOTH_RATES, .MAX_PAYLOAD_LENGTH, .RX_STORED_LEN,
		.RX_TRUNCATED, .IRQ);

	always #12.5 CLK_SYS = ~CLK_SYS;

	task automatic final_report;
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// hang guard, well above the length of the sequence
	always @(posedge CLK_SYS)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			final_report();
		end
	end

	// handshakes are judged at the falling edge, so no race with the slave's flops
	task automatic wr(input logic [11:0] a, input logic [31:0] dt, output logic [1:0] rs);
		logic ta, tw, b;
		b = 0;
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= dt;
		S_AXI_AWVALID <= 1;
		S_AXI_WVALID <= 1;
		S_AXI_BREADY <= 1;
		while (!b)
		begin
			@(negedge CLK_SYS);
			ta = S_AXI_AWVALID & S_AXI_AWREADY;
			tw = S_AXI_WVALID & S_AXI_WREADY;
			b = S_AXI_BVALID;
			rs = S_AXI_BRESP;
			@(posedge CLK_SYS);
			if (ta) S_AXI_AWVALID <= 0;
			if (tw) S_AXI_WVALID <= 0;
		end
		S_AXI_BREADY <= 0;
		@(posedge CLK_SYS);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] dt, output logic [1:0] rs);
		logic t, v;
		v = 0;
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1;
		S_AXI_RREADY <= 1;
		while (!v)
		begin
			@(negedge CLK_SYS);
			t = S_AXI_ARVALID & S_AXI_ARREADY;
			v = S_AXI_RVALID;
			dt = S_AXI_RDATA;
			rs = S_AXI_RRESP;
			@(posedge CLK_SYS);
			if (t) S_AXI_ARVALID <= 0;
		end
		S_AXI_RREADY <= 0;
		@(posedge CLK_SYS);
	endtask

	task automatic wchk(input logic [11:0] a, input logic [31:0] dt);
		logic [1:0] rs;
		wr(a, dt, rs);
		`CHK(rs, RESP_OKAY)
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] dt;
		logic [1:0]  rs;
		rd(a, dt, rs);
		`CHK(dt, e)
		`CHK(rs, RESP_OKAY)
	endtask

	task automatic pulse_end;
		RX_END <= 1;
		@(posedge CLK_SYS);
		RX_END <= 0;
		repeat (2) @(posedge CLK_SYS);
	endtask

	initial
	begin
		logic [31:0] d;
		logic [1:0]  r;
		{CLK_SYS, RST_B, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID} = '0;
		{S_AXI_RREADY, RX_FRAME_START, RX_END, RX_CRC_OK, CODING_INDICATOR_VALID} = '0;
		{CODING_INDICATOR, SAMPLER_FSM_STATE, TRANSMIT_READY_EVENT, RECEIVE_READY_EVENT} = '0;
		{MAC_HEADER_MATCH_EVENT, PHYSICAL_END_EVENT, TONE_EXTENSION_FOUND_EVENT} = '0;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, RX_LOGICAL_ADDR, RX_MATCH_INDEX} = '0;
		{ANTENNA_SWITCH_FSM_STATE, RX_CHECK_VALUE, RX_PAYLOAD_LEN, RX_TONE_INFO} = '0;
		S_AXI_WSTRB = 4'hf;
		{miscompares, compares, cyc} = '0;
		repeat (6) @(posedge CLK_SYS);
		RST_B <= 1;
		@(posedge CLK_SYS);
		foreach (ro[i]) rchk(ro[i], 32'h0000_0000);
		rchk(OFF_FREQ, FREQ_RESET);
		`CHK(CARRIER_MHZ, 12'h962)
		wchk(OFF_CRC_RESULT, 32'h0000_0001);
		rchk(OFF_CRC_RESULT, 32'h0000_0000);
		rd(12'h7fc, d, r);
		`CHK(r, RESP_SLVERR)
		`CHK(d, 32'h0000_0000)
		wr(12'h7fc, 32'h0000_ffff, r);
		`CHK(r, RESP_SLVERR)
		wchk(OFF_FREQ, 32'h0000_0164);
		rchk(OFF_FREQ, 32'h0000_0164);
		`CHK(CARRIER_MHZ, 12'h99c)
		wchk(OFF_FREQ, 32'h0000_0064);
		`CHK(CARRIER_MHZ, 12'h9c4)
		wchk(OFF_PKT_PTR, 32'h2000_1235);
		rchk(OFF_PKT_PTR, 32'h2000_1235);
		`CHK(PACKET_DMA_POINTER, 32'h2000_1235)
		// only the strobed byte of the pointer may change
		S_AXI_WSTRB <= 4'h2;
		wchk(OFF_PKT_PTR, 32'hffff_ffff);
		S_AXI_WSTRB <= 4'hf;
		rchk(OFF_PKT_PTR, 32'h2000_ff35);
		foreach (pw[i])
		begin
			wchk(OFF_TX_POWER, {24'h0, pw[i]});
			rchk(OFF_TX_POWER, {24'h0, pw[i]});
			`CHK(OUTPUT_POWER, pw[i])
		end
		// the long-range modes must send at one rate but listen at both
		foreach (md[i])
		begin
			wchk(OFF_MODE, {28'h0, md[i]});
			rchk(OFF_MODE, {28'h0, md[i]});
			`CHK(RADIO_MODE, md[i])
			`CHK(TX_RATE_500K, md[i] == 4'h6)
			`CHK(RX_ACCEPT_BOTH_RATES, md[i] == 4'h5 || md[i] == 4'h6)
		end
		for (int s = 0; s < 6; s++)
		begin
			ANTENNA_SWITCH_FSM_STATE <= 3'(s);
			SAMPLER_FSM_STATE <= s[0];
			rchk(OFF_DF_STATE, 32'(s) | (32'(s[0]) << 4));
		end
		wchk(OFF_MODE, 32'h0000_0005);
		wchk(OFF_PCFG1, 32'h0000_000a);
		`CHK(MAX_PAYLOAD_LENGTH, 8'h0a)
		RX_FRAME_START <= 1;
		@(posedge CLK_SYS);
		RX_FRAME_START <= 0;
		CODING_INDICATOR_VALID <= 1;
		CODING_INDICATOR <= 1;
		RX_CRC_OK <= 1;
		RX_LOGICAL_ADDR <= 3'h5;
		RX_CHECK_VALUE <= 24'habcdef;
		RX_MATCH_INDEX <= 3'h6;
		RX_PAYLOAD_LEN <= 8'h0c;
		RX_TONE_INFO <= 8'ha5;
		@(posedge CLK_SYS);
		CODING_INDICATOR_VALID <= 0;
		@(negedge CLK_SYS);
		`CHK(RX_STORED_LEN, 8'h0a)
		`CHK(RX_TRUNCATED, 1'b1)
		@(posedge CLK_SYS);
		pulse_end();
		rchk(OFF_CRC_RESULT, 32'h0000_0001);
		rchk(OFF_RX_LADDR, 32'h0000_0005);
		rchk(OFF_RX_CHECK, 32'h00ab_cdef);
		rchk(OFF_DEV_MATCH, 32'h0000_0006);
		rchk(OFF_PAY_STATUS, 32'h0000_0003);
		rchk(OFF_TONE_INFO, 32'h0000_00a5);
		rchk(OFF_EVT_STATUS, 32'h1 << EVB_RATE_SWITCH);
		`CHK(IRQ, 1'b0)
		wchk(OFF_INT_ENABLE, 32'h1 << EVB_RATE_SWITCH);
		`CHK(IRQ, 1'b1)
		wchk(OFF_INT_DISABLE, 32'h0000_0000);
		rchk(OFF_INT_DISABLE, 32'h1 << EVB_RATE_SWITCH);
		wchk(OFF_INT_DISABLE, 32'h1 << EVB_RATE_SWITCH);
		rchk(OFF_INT_DISABLE, 32'h0000_0000);
		`CHK(IRQ, 1'b0)
		wchk(OFF_EVT_STATUS, 32'h1 << EVB_RATE_SWITCH);
		rchk(OFF_EVT_STATUS, 32'h0000_0000);
		// new inputs without an end strobe must not disturb the held status
		RX_CRC_OK <= 0;
		RX_LOGICAL_ADDR <= 3'h2;
		RX_PAYLOAD_LEN <= 8'h0a;
		rchk(OFF_CRC_RESULT, 32'h0000_0001);
		rchk(OFF_RX_LADDR, 32'h0000_0005);
		`CHK(RX_STORED_LEN, 8'h0a)
		`CHK(RX_TRUNCATED, 1'b0)
		RX_FRAME_START <= 1;
		@(posedge CLK_SYS);
		RX_FRAME_START <= 0;
		pulse_end();
		rchk(OFF_CRC_RESULT, 32'h0000_0000);
		rchk(OFF_RX_LADDR, 32'h0000_0002);
		rchk(OFF_PAY_STATUS, 32'h0000_0000);
		// outside long range the indicator must not raise the rate
		wchk(OFF_MODE, 32'h0000_0003);
		CODING_INDICATOR_VALID <= 1;
		@(posedge CLK_SYS);
		CODING_INDICATOR_VALID <= 0;
		repeat (2) @(posedge CLK_SYS);
		rchk(OFF_EVT_STATUS, 32'h0000_0000);
		{TRANSMIT_READY_EVENT, RECEIVE_READY_EVENT, MAC_HEADER_MATCH_EVENT} <= 3'h7;
		{PHYSICAL_END_EVENT, TONE_EXTENSION_FOUND_EVENT} <= 2'h3;
		@(posedge CLK_SYS);
		{TRANSMIT_READY_EVENT, RECEIVE_READY_EVENT, MAC_HEADER_MATCH_EVENT} <= 3'h0;
		{PHYSICAL_END_EVENT, TONE_EXTENSION_FOUND_EVENT} <= 2'h0;
		rchk(OFF_EVT_STATUS, 32'h01b8_0000);
		wchk(OFF_INT_ENABLE, EVT_MASK);
		`CHK(IRQ, 1'b1)
		wchk(OFF_INT_DISABLE, EVT_MASK);
		rchk(OFF_INT_DISABLE, 32'h0000_0000);
		`CHK(IRQ, 1'b0)
		final_report();
	end
endmodule
